//--- hdl/bdms_serial.sv
// Serial shift engine: command capture and status shift-out
`timescale 1ns/1ps
module bdms_serial
#(
   parameter int WIDTH = bdms_pkg::FRAME_BITS
)
(
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic              ce,
   input  wire logic              clr,
   input  wire logic              sel_n,
   input  wire logic              sclk,
   input  wire logic              sin,
   input  wire logic [WIDTH-1:0]  status,
   output logic                   sout,
   output logic [WIDTH-1:0]       cmd,
   output logic                   cmd_stb
);

   // Shift path needs at least two bits
   if (WIDTH < 2)
   begin : g_bad_width
      $error("bdms_serial: WIDTH too small");
   end

   logic [WIDTH-1:0] sh_r, sh_nxt;
   logic [$clog2(WIDTH+1)-1:0] cnt_r, cnt_nxt;
   logic sclk_r, sclk_nxt, sel_r, sel_nxt, stb_nxt, stb_r;
   logic [WIDTH-1:0] cmd_r, cmd_nxt;

   always_comb
   begin
      sh_nxt   = sh_r;
      cnt_nxt  = cnt_r;
      cmd_nxt  = cmd_r;
      stb_nxt  = 1'b0;
      sclk_nxt = sclk;
      sel_nxt  = sel_n;
      if (clr)
      begin
         sh_nxt  = '0;
         cnt_nxt = '0;
         cmd_nxt = '0;
      end
      else if (sel_r && !sel_n)
      begin
         sh_nxt  = status;
         cnt_nxt = '0;
      end
      else if (!sel_n && sclk && !sclk_r)
      begin
         sh_nxt  = {sh_r[WIDTH-2:0], sin};
         if (cnt_r != WIDTH[$clog2(WIDTH+1)-1:0])
            cnt_nxt = cnt_r + 1'b1;
      end
      else if (!sel_r && sel_n && cnt_r == WIDTH[$clog2(WIDTH+1)-1:0])
      begin
         // Only frames of at least WIDTH clocks reach the input register
         cmd_nxt = sh_r;
         stb_nxt = 1'b1;
         cnt_nxt = '0;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sh_r   <= '0;
         cnt_r  <= '0;
         cmd_r  <= '0;
         stb_r  <= 1'b0;
         sclk_r <= 1'b0;
         sel_r  <= 1'b1;
      end
      else if (ce)
      begin
         sh_r   <= sh_nxt;
         cnt_r  <= cnt_nxt;
         cmd_r  <= cmd_nxt;
         stb_r  <= stb_nxt;
         sclk_r <= sclk_nxt;
         sel_r  <= sel_nxt;
      end
   end

   assign sout    = sh_r[WIDTH-1];
   assign cmd     = cmd_r;
   assign cmd_stb = stb_r;

endmodule // bdms_serial

//--- hdl/bdms_top.sv
// Mode sequencer: power-on reset, standby, active mode and gate gating
`timescale 1ns/1ps
module bdms_top
#(
   parameter int WIDTH   = bdms_pkg::FRAME_BITS,
   parameter int GAP_CYC = bdms_pkg::SEL_GAP_CYC
)
(
   input  wire logic                CLOCK,
   input  wire logic                RESETN,
   input  wire logic                CE,
   input  wire logic                LOGIC_ABOVE_RELEASE,
   input  wire logic                LOGIC_BELOW_ASSERT,
   input  wire logic                ENABLE,
   input  wire logic                SERIAL_SELECT_LOW_N,
   input  wire logic                SERIAL_CLK,
   input  wire logic                SERIAL_IN,
   input  wire bdms_pkg::bdms_fault_t FAULTS,
   output logic                     SERIAL_OUT,
   output logic                     SERIAL_OUT_OE,
   output bdms_pkg::bdms_gate_t     GATE,
   output logic                     ACTIVE,
   output logic                     DIAG_RUN,
   output logic [WIDTH-1:0]         CTRL_REG,
   output logic                     GAP_VIOLATION
);

   // Status word carries four fault bits plus padding
   if (WIDTH < 5 || GAP_CYC < 1)
   begin : g_bad_param
      $error("bdms_top: bad parameter");
   end

   // ******************************************
   // Mode state machine
   // ******************************************
   bdms_pkg::bdms_mode_t mode_r, mode_nxt;
   logic [2:0] por_cnt_r, por_cnt_nxt;
   logic clr;

   always_comb
   begin
      mode_nxt    = mode_r;
      por_cnt_nxt = por_cnt_r;
      unique case (mode_r)
         bdms_pkg::BDMS_ST_POR:
         begin
            // Hold reset a few cycles after supply comes up
            if (LOGIC_ABOVE_RELEASE && !LOGIC_BELOW_ASSERT)
            begin
               if (por_cnt_r == 3'(bdms_pkg::POR_HOLD_CYC - 1))
                  mode_nxt = bdms_pkg::BDMS_ST_STANDBY;
               else
                  por_cnt_nxt = por_cnt_r + 3'h1;
            end
            else
               por_cnt_nxt = 3'h0;
         end
         bdms_pkg::BDMS_ST_STANDBY:
         begin
            if (LOGIC_BELOW_ASSERT)
               mode_nxt = bdms_pkg::BDMS_ST_POR;
            else if (ENABLE && LOGIC_ABOVE_RELEASE)
               mode_nxt = bdms_pkg::BDMS_ST_ACTIVE;
         end
         bdms_pkg::BDMS_ST_ACTIVE:
         begin
            if (LOGIC_BELOW_ASSERT)
               mode_nxt = bdms_pkg::BDMS_ST_POR;
            else if (!ENABLE)
               mode_nxt = bdms_pkg::BDMS_ST_STANDBY;
         end
         default: mode_nxt = bdms_pkg::BDMS_ST_POR;
      endcase
      if (mode_nxt != bdms_pkg::BDMS_ST_POR || mode_r != bdms_pkg::BDMS_ST_POR)
         if (mode_nxt != mode_r) por_cnt_nxt = 3'h0;
   end

   always_ff @(posedge CLOCK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         mode_r    <= bdms_pkg::BDMS_ST_POR;
         por_cnt_r <= 3'h0;
      end
      else if (CE)
      begin
         mode_r    <= mode_nxt;
         por_cnt_r <= por_cnt_nxt;
      end
   end

   // Motor supply loss enters only as a fault flag, so it cannot touch state
   assign clr = (mode_r != bdms_pkg::BDMS_ST_ACTIVE);

   // ******************************************
   // Serial engine
   // ******************************************
   logic [WIDTH-1:0] cmd;
   logic cmd_stb, sout;
   logic [WIDTH-1:0] status;

   assign status = {{(WIDTH-4){1'b0}}, FAULTS};

   bdms_serial #(.WIDTH(WIDTH)) u_serial
   (
      .clk     (CLOCK),
      .rst_n   (RESETN),
      .ce      (CE),
      .clr     (clr),
      .sel_n   (SERIAL_SELECT_LOW_N),
      .sclk    (SERIAL_CLK),
      .sin     (SERIAL_IN),
      .status  (status),
      .sout    (sout),
      .cmd     (cmd),
      .cmd_stb (cmd_stb)
   );

   // ******************************************
   // Control register, gating and outputs
   // ******************************************
   logic [WIDTH-1:0] ctrl_r, ctrl_nxt;
   logic pump_lock_r, pump_lock_nxt;
   logic [$clog2(GAP_CYC+1)-1:0] gap_r, gap_nxt;
   logic gapv_r, gapv_nxt, sel_q_r;
   bdms_pkg::bdms_gate_t gate_r, gate_nxt;
   logic out_r, out_nxt, oe_r, oe_nxt, act_r;

   always_comb
   begin
      ctrl_nxt      = ctrl_r;
      pump_lock_nxt = pump_lock_r;
      gap_nxt       = gap_r;
      gapv_nxt      = 1'b0;
      if (clr)
      begin
         ctrl_nxt      = WIDTH'(bdms_pkg::CTRL_RST);
         pump_lock_nxt = FAULTS.motor_supply_overvoltage;
         gap_nxt       = '0;
      end
      else
      begin
         if (cmd_stb)
            ctrl_nxt = cmd;
         // Lock clears only once the overvoltage is gone
         if (!FAULTS.motor_supply_overvoltage)
            pump_lock_nxt = 1'b0;
         if (SERIAL_SELECT_LOW_N && gap_r != GAP_CYC[$bits(gap_r)-1:0])
            gap_nxt = gap_r + 1'b1;
         if (sel_q_r && !SERIAL_SELECT_LOW_N)
         begin
            // Flag only; the frame is still taken
            gapv_nxt = (gap_r != GAP_CYC[$bits(gap_r)-1:0]);
            gap_nxt  = '0;
         end
      end
      gate_nxt.drivers_on = !clr && ctrl_r[bdms_pkg::CTRL_DRV_EN_BIT] && !FAULTS.thermal
                            && !FAULTS.short_circuit && !FAULTS.motor_supply_undervoltage
                            && !FAULTS.motor_supply_overvoltage;
      gate_nxt.pump_on    = !clr && ctrl_r[bdms_pkg::CTRL_CP_EN_BIT] && !pump_lock_r
                            && !FAULTS.motor_supply_overvoltage;
      oe_nxt  = !SERIAL_SELECT_LOW_N && !clr;
      out_nxt = oe_nxt ? sout : 1'b0;
   end

   always_ff @(posedge CLOCK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         ctrl_r      <= WIDTH'(bdms_pkg::CTRL_RST);
         pump_lock_r <= 1'b1;
         gap_r       <= '0;
         gapv_r      <= 1'b0;
         sel_q_r     <= 1'b1;
         gate_r      <= '0;
         out_r       <= 1'b0;
         oe_r        <= 1'b0;
         act_r       <= 1'b0;
      end
      else if (CE)
      begin
         ctrl_r      <= ctrl_nxt;
         pump_lock_r <= pump_lock_nxt;
         gap_r       <= gap_nxt;
         gapv_r      <= gapv_nxt;
         sel_q_r     <= SERIAL_SELECT_LOW_N;
         gate_r      <= gate_nxt;
         out_r       <= out_nxt;
         oe_r        <= oe_nxt;
         act_r       <= !clr;
      end
   end

   assign SERIAL_OUT    = out_r;
   assign SERIAL_OUT_OE = oe_r;
   assign GATE          = gate_r;
   assign ACTIVE        = act_r;
   assign DIAG_RUN      = act_r;
   assign CTRL_REG      = ctrl_r;
   assign GAP_VIOLATION = gapv_r;

   // ******************************************
   // Checks
   // ******************************************
   undervolt_gates_off_a: assert property (@(posedge CLOCK) disable iff (!RESETN)
      CE && LOGIC_BELOW_ASSERT ##1 CE [*1] ##1 CE |-> GATE == '0)
      else $error("gates on after logic supply loss");

   standby_clears_a: assert property (@(posedge CLOCK) disable iff (!RESETN)
      CE && mode_r != bdms_pkg::BDMS_ST_ACTIVE |=> !CE || (ctrl_r == bdms_pkg::CTRL_RST))
      else $error("state not cleared in standby");

   enable_low_standby_a: assert property (@(posedge CLOCK) disable iff (!RESETN)
      CE && !ENABLE |=> !CE || mode_r != bdms_pkg::BDMS_ST_ACTIVE)
      else $error("active with enable low");

   active_entry_a: assert property (@(posedge CLOCK) disable iff (!RESETN)
      CE && mode_r != bdms_pkg::BDMS_ST_ACTIVE && !(ENABLE && LOGIC_ABOVE_RELEASE)
      |=> mode_r != bdms_pkg::BDMS_ST_ACTIVE)
      else $error("active without enable and supply");

   out_hiz_a: assert property (@(posedge CLOCK) disable iff (!RESETN)
      CE && SERIAL_SELECT_LOW_N |=> !CE || !SERIAL_OUT_OE)
      else $error("serial out driven with select high");

   standby_hiz_a: assert property (@(posedge CLOCK) disable iff (!RESETN)
      CE && clr |=> !CE || !SERIAL_OUT_OE)
      else $error("serial out driven in standby");

   ov_pump_off_a: assert property (@(posedge CLOCK) disable iff (!RESETN)
      CE && clr && FAULTS.motor_supply_overvoltage
      ##1 CE && !clr && FAULTS.motor_supply_overvoltage
      |=> !GATE.pump_on)
      else $error("pump on after entry with overvoltage");

   fault_drv_off_a: assert property (@(posedge CLOCK) disable iff (!RESETN)
      CE && (FAULTS.thermal || FAULTS.short_circuit) |=> !GATE.drivers_on)
      else $error("drivers on with fault flag");

   por_release_a: assert property (@(posedge CLOCK) disable iff (!RESETN)
      mode_r == bdms_pkg::BDMS_ST_POR ##1 mode_r == bdms_pkg::BDMS_ST_STANDBY
      |-> $past(por_cnt_r) == 3'(bdms_pkg::POR_HOLD_CYC - 1))
      else $error("power-on reset released early");

endmodule // bdms_top

//--- inc/bdms_pkg.sv
// Package: constants and carrier types for the bridge driver mode sequencer
package bdms_pkg;

   // ******************************************
   // Timing
   // ******************************************
   localparam int CLK_PERIOD_NS    = 10;
   localparam int SEL_GAP_US       = 2;
   localparam int SEL_GAP_CYC      = (SEL_GAP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int POR_HOLD_CYC     = 4;

   // ******************************************
   // Frame and reset values
   // ******************************************
   localparam int FRAME_BITS       = 16;
   localparam logic [15:0] CTRL_RST = 16'h0000;
   localparam logic [15:0] STAT_RST = 16'h0000;
   localparam int CTRL_DRV_EN_BIT  = 0;
   localparam int CTRL_CP_EN_BIT   = 1;

   typedef enum logic [1:0] {BDMS_ST_POR, BDMS_ST_STANDBY, BDMS_ST_ACTIVE} bdms_mode_t;

   typedef struct packed {
      logic motor_supply_overvoltage;
      logic motor_supply_undervoltage;
      logic thermal;
      logic short_circuit;
   } bdms_fault_t;

   typedef struct packed {
      logic drivers_on;
      logic pump_on;
   } bdms_gate_t;

endpackage

//--- verification/bdms_host.sv
// Host serial master model for the mode sequencer
`timescale 1ns/1ps
module bdms_host
(
   input  wire logic clk,
   output logic      sel_n,
   output logic      sclk,
   output logic      sin,
   input  wire logic sout,
   input  wire logic sout_oe
);
   int oe_miss;

   initial
   begin
      sel_n = 1'b1;
      sclk = 1'b0;
      sin = 1'b1;
      oe_miss = 0;
   end

   // Clock stands low between frames; data line shows the inverse once released
   task automatic xfer(input logic [15:0] cmd, input int gap, output logic [15:0] rsp);
      repeat (gap) @(negedge clk);
      sel_n = 1'b0;
      for (int i = 15; i >= 0; i--)
      begin
         sin = cmd[i];
         repeat (3) @(negedge clk);
         rsp[i] = sout;
         if (sout_oe !== 1'b1)
            oe_miss++;
         sclk = 1'b1;
         repeat (3) @(negedge clk);
         sclk = 1'b0;
      end
      repeat (2) @(negedge clk);
      sel_n = 1'b1;
      sin = ~cmd[0];
   endtask
endmodule // bdms_host

//--- verification/bdms_top_tb.sv
// Self-checking bench for the mode sequencer
`timescale 1ns/1ps
module bdms_top_tb;
   localparam int GAP = 20;
   logic                  clock = 1'b0;
   logic                  resetn, above, below, enable;
   logic                  sel_n, sclk, sin, sout, oe, active, diag, gap_v;
   logic [1:0]            sel_h = 2'b00;
   logic [15:0]           ctrl, rsp;
   bdms_pkg::bdms_fault_t faults;
   bdms_pkg::bdms_gate_t  gate;
   int                    errors = 0, n_compared = 0, gap_hits = 0, h;

   always #5 clock = ~clock;

   bdms_top #(.WIDTH(16), .GAP_CYC(GAP)) bdms_top_i (.CLOCK(clock), .RESETN(resetn),
      .CE(1'b1), .LOGIC_ABOVE_RELEASE(above), .LOGIC_BELOW_ASSERT(below), .ENABLE(enable),
      .SERIAL_SELECT_LOW_N(sel_n), .SERIAL_CLK(sclk), .SERIAL_IN(sin), .FAULTS(faults),
      .SERIAL_OUT(sout), .SERIAL_OUT_OE(oe), .GATE(gate), .ACTIVE(active),
      .DIAG_RUN(diag), .CTRL_REG(ctrl), .GAP_VIOLATION(gap_v));

   bdms_host bdms_host_i (.clk(clock), .sel_n(sel_n), .sclk(sclk), .sin(sin),
      .sout(sout), .sout_oe(oe));

   // ******************************************
   // Shared tasks
   // ******************************************
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp)
      begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic complete_run();
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic wait_active(input logic exp);
      int n;
      n = 0;
      while (active !== exp && n < 200)
      begin
         @(negedge clock);
         n++;
      end
      if (n >= 200)
      begin
         errors++;
         complete_run();
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clock);
   endtask

   // Five cycles covers strobe, register and gate update after select rises
   task automatic send(input logic [15:0] cmd, input int gap);
      bdms_host_i.xfer(cmd, gap, rsp);
      cyc(5);
   endtask

   // Output enable must be down once select has stood high for two edges
   always @(posedge clock)
      sel_h <= {sel_h[0], sel_n};
   // Pulse counted at the falling edge, where it has settled
   always @(negedge clock)
   begin
      if (gap_v === 1'b1)
         gap_hits++;
      if (sel_h === 2'b11 && sel_n === 1'b1)
         chk("oe idle", 16'h0000, {15'h0000, oe});
   end

   // ******************************************
   // Scenarios
   // ******************************************
   task automatic t_por();
      cyc(20);
      chk("active low supply", 16'h0000, {15'h0000, active});
      chk("gate low supply", 16'h0000, {14'h0000, gate});
      above = 1'b1;
      wait_active(1'b1);
      chk("diag", 16'h0001, {15'h0000, diag});
   endtask

   task automatic t_cmd();
      send(16'h0003, GAP + 2);
      chk("ctrl", 16'h0003, ctrl);
      chk("gate", 16'h0003, {14'h0000, gate});
      chk("status", 16'h0000, rsp);
      chk("oe frame", 16'h0000, bdms_host_i.oe_miss[15:0]);
      faults = 4'h2;
      send(16'h0003, GAP + 2);
      chk("status fault", 16'h0002, rsp);
      chk("gate fault", 16'h0000, {15'h0000, gate.drivers_on});
      faults = 4'h0;
      cyc(5);
      chk("gate clear", 16'h0003, {14'h0000, gate});
   endtask

   task automatic t_gap();
      h = gap_hits;
      send(16'h0001, GAP + 2);
      chk("gap ok", h[15:0], gap_hits[15:0]);
      send(16'h0002, 2);
      chk("gap short", h[15:0] + 16'h0001, gap_hits[15:0]);
      chk("ctrl short", 16'h0002, ctrl);
      send(16'h0003, GAP + 2);
   endtask

   task automatic t_motor();
      faults = 4'h4;
      cyc(5);
      chk("ctrl motor off", 16'h0003, ctrl);
      faults = 4'h0;
   endtask

   task automatic t_standby();
      enable = 1'b0;
      wait_active(1'b0);
      cyc(2);
      chk("ctrl standby", 16'h0000, ctrl);
      chk("gate standby", 16'h0000, {14'h0000, gate});
      chk("diag standby", 16'h0000, {15'h0000, diag});
      send(16'h0003, GAP + 2);
      chk("ctrl ignored", 16'h0000, ctrl);
   endtask

   task automatic t_ov();
      faults = 4'h8;
      enable = 1'b1;
      wait_active(1'b1);
      send(16'h0003, GAP + 2);
      chk("pump ov", 16'h0000, {15'h0000, gate.pump_on});
      faults = 4'h0;
      cyc(5);
      chk("pump ov gone", 16'h0003, {14'h0000, gate});
   endtask

   task automatic t_brown();
      below = 1'b1;
      cyc(3);
      chk("gate brown", 16'h0000, {14'h0000, gate});
      chk("ctrl brown", 16'h0000, ctrl);
      chk("active brown", 16'h0000, {15'h0000, active});
      below = 1'b0;
      wait_active(1'b1);
      chk("ctrl after por", 16'h0000, ctrl);
   endtask

   initial
   begin
      resetn = 1'b0;
      above = 1'b0;
      below = 1'b0;
      enable = 1'b1;
      faults = 4'h0;
      cyc(10);
      resetn = 1'b1;
      t_por();
      t_cmd();
      t_gap();
      t_motor();
      t_standby();
      t_ov();
      t_brown();
      complete_run();
   end
endmodule // bdms_top_tb
